// >>> hdl/rxf_pkg.sv
// constants shared by the receive framer/decoder channel
// assumes three-level selects arrive encoded as two bits (open reads as mid)
package rxf_pkg;
	// three-level select encodings
	localparam logic [1:0] SEL_LOW = 2'h0;
	localparam logic [1:0] SEL_MID = 2'h1;
	localparam logic [1:0] SEL_HIGH = 2'h2;
	// character geometry
	localparam int CHAR_BITS = 10;
	localparam logic [3:0] CNT_LAST = 4'h9;
	localparam logic [3:0] CNT_HALF = 4'h5;
	localparam logic [1:0] MAX_STRETCH = 2'h2;
	// framing patterns, first received bit on the left
	localparam logic [7:0] COMMA_POS = 8'h3E;
	localparam logic [7:0] COMMA_NEG = 8'hC1;
	localparam logic [9:0] K285_NEG = 10'h0FA;
	localparam logic [9:0] K285_POS = 10'h305;
	// multi-byte framer figures
	localparam logic [5:0] MB_SPAN_BITS = 6'h32;
	localparam logic [5:0] MB_CHAR_BITS = 6'h0A;
	localparam logic [2:0] MB_ALT_RUN = 3'h4;
	// transition density figures
	localparam logic [6:0] FAULT_QUIET_BITS = 7'h3C;
	localparam logic [1:0] FAULT_GOOD_CHARS = 2'h3;
	// training clock ratios
	localparam logic [5:0] TRN_RATIO_CHAR = 6'h0A;
	localparam logic [5:0] TRN_RATIO_HALF = 6'h14;
	// receive status codes
	localparam logic [2:0] ST_DATA = 3'h0;
	localparam logic [2:0] ST_SPECIAL = 3'h1;
	localparam logic [2:0] ST_FRAME = 3'h2;
	localparam logic [2:0] ST_INVALID = 3'h5;
	localparam logic [2:0] ST_DISP = 3'h6;
	localparam logic [2:0] ST_NOSYNC = 3'h7;
	// alternate special column base
	localparam logic [7:0] ALT_K7_BASE = 8'h08;
	// framer progress, gray along hunt-check-lock
	typedef enum logic [1:0] {
		RXF_HUNT = 2'h0,
		RXF_CHECK = 2'h1,
		RXF_LOCK = 2'h3
	} rxf_sync_t;
endpackage : rxf_pkg

// >>> hdl/rxf_stream_if.sv
// valid/ready carrier between the framer core and its two-entry buffer
// assumes one clock shared by both ends
interface rxf_stream_if #(parameter int W = 14);
	logic [W-1:0] wdata;
	logic wvalid;
	logic wready;
	logic [W-1:0] rdata;
	logic rvalid;
	logic rready;
	modport buf_side (input wdata, input wvalid, output wready, output rdata, output rvalid, input rready);
	modport user_side (output wdata, output wvalid, input wready, input rdata, input rvalid, output rready);
endinterface : rxf_stream_if

// >>> hdl/rxf_skid_buf.sv
// two-entry buffer, read data from a register
// assumes core clock, async active-low reset and a freezing clock enable
module rxf_skid_buf #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// stream
	rxf_stream_if.buf_side sif
);
	generate
		if (DEPTH != 2 || WIDTH < 1) begin : g_chk
			$error("rxf_skid_buf supports exactly two entries");
		end
	endgenerate

	logic out_vld_ff, spr_vld_ff;
	logic [WIDTH-1:0] out_ff, spr_ff;
	logic nxt_out_vld, nxt_spr_vld;
	logic [WIDTH-1:0] nxt_out, nxt_spr;
	wire take = sif.wvalid && !spr_vld_ff;
	wire pop = out_vld_ff && sif.rready;

	assign sif.wready = !spr_vld_ff;
	assign sif.rvalid = out_vld_ff;
	assign sif.rdata = out_ff;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_out_vld = out_vld_ff;
		nxt_out = out_ff;
		nxt_spr_vld = spr_vld_ff;
		nxt_spr = spr_ff;
		if (!out_vld_ff || pop) begin
			if (spr_vld_ff) begin
				nxt_out = spr_ff;
				nxt_out_vld = 1'b1;
				nxt_spr_vld = 1'b0;
			end else begin
				nxt_out = sif.wdata;
				nxt_out_vld = take;
			end
		end else if (take) begin
			nxt_spr = sif.wdata;
			nxt_spr_vld = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_vld_ff <= 1'b0;
			spr_vld_ff <= 1'b0;
			out_ff <= '0;
			spr_ff <= '0;
		end else if (clk_en_in) begin
			out_vld_ff <= nxt_out_vld;
			spr_vld_ff <= nxt_spr_vld;
			out_ff <= nxt_out;
			spr_ff <= nxt_spr;
		end
	end
endmodule : rxf_skid_buf

// >>> hdl/rxf_rx_framer.sv
// one receive channel: range monitor, framer, 10b/8b decoder, parity
// assumes one serial bit per enabled core clock; config inputs are core-clock logic

module rxf_rx_framer #(
	parameter int TRN_TOL = 2
) (
	// clock, reset, enable
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// serial pins
	input wire logic primary_serial_input_in,
	input wire logic secondary_serial_input_in,
	input wire logic training_clock_in,
	// configuration
	input wire logic line_input_select_in,
	input wire logic training_rate_select_in,
	input wire logic [1:0] framing_pattern_select_in,
	input wire logic [1:0] framer_type_select_in,
	input wire logic global_framer_enable_in,
	input wire logic output_clock_rate_select_in,
	input wire logic [1:0] decoder_mode_select_in,
	input wire logic [1:0] receive_clock_source_select_in,
	// status
	output logic recovered_char_clock_out,
	output logic link_fault_indicator_out,
	output logic tracking_training_out,
	output logic framing_locked_out,
	output logic config_error_out,
	output logic overflow_out,
	// parallel output
	output logic [9:0] rx_data_out,
	output logic [2:0] receive_status_code_out,
	output logic rx_parity_out,
	output logic rx_valid_out,
	input wire logic rx_ready_in
);
	generate
		if (TRN_TOL < 0 || TRN_TOL > 9) begin : g_chk
			$error("rxf_rx_framer TRN_TOL out of range");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// decode tables
	function automatic logic [5:0] dec6(input logic [5:0] c);
		case (c)
			6'b100111, 6'b011000: dec6 = 6'h20;
			6'b011101, 6'b100010: dec6 = 6'h21;
			6'b101101, 6'b010010: dec6 = 6'h22;
			6'b110001: dec6 = 6'h23;
			6'b110101, 6'b001010: dec6 = 6'h24;
			6'b101001: dec6 = 6'h25;
			6'b011001: dec6 = 6'h26;
			6'b111000, 6'b000111: dec6 = 6'h27;
			6'b111001, 6'b000110: dec6 = 6'h28;
			6'b100101: dec6 = 6'h29;
			6'b010101: dec6 = 6'h2A;
			6'b110100: dec6 = 6'h2B;
			6'b001101: dec6 = 6'h2C;
			6'b101100: dec6 = 6'h2D;
			6'b011100: dec6 = 6'h2E;
			6'b010111, 6'b101000: dec6 = 6'h2F;
			6'b011011, 6'b100100: dec6 = 6'h30;
			6'b100011: dec6 = 6'h31;
			6'b010011: dec6 = 6'h32;
			6'b110010: dec6 = 6'h33;
			6'b001011: dec6 = 6'h34;
			6'b101010: dec6 = 6'h35;
			6'b011010: dec6 = 6'h36;
			6'b111010, 6'b000101: dec6 = 6'h37;
			6'b110011, 6'b001100: dec6 = 6'h38;
			6'b100110: dec6 = 6'h39;
			6'b010110: dec6 = 6'h3A;
			6'b110110, 6'b001001: dec6 = 6'h3B;
			6'b001110, 6'b001111, 6'b110000: dec6 = 6'h3C;
			6'b101110, 6'b010001: dec6 = 6'h3D;
			6'b011110, 6'b100001: dec6 = 6'h3E;
			6'b101011, 6'b010100: dec6 = 6'h3F;
			default: dec6 = 6'h00;
		endcase
	endfunction : dec6

	function automatic logic [3:0] dec4(input logic [3:0] c);
		case (c)
			4'b1011, 4'b0100: dec4 = 4'h8;
			4'b1001: dec4 = 4'h9;
			4'b0101: dec4 = 4'hA;
			4'b1100, 4'b0011: dec4 = 4'hB;
			4'b1101, 4'b0010: dec4 = 4'hC;
			4'b1010: dec4 = 4'hD;
			4'b0110: dec4 = 4'hE;
			4'b1110, 4'b0001, 4'b0111, 4'b1000: dec4 = 4'hF;
			default: dec4 = 4'h0;
		endcase
	endfunction : dec4

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and line select
	logic [1:0] pri_sync_ff, sec_sync_ff, trn_sync_ff;
	logic trn_d_ff, sel_d_ff;
	logic [9:0] sh_ff;
	wire bit_in = line_input_select_in ? sec_sync_ff[1] : pri_sync_ff[1];
	wire line_swap = line_input_select_in != sel_d_ff;
	wire trn_edge = trn_sync_ff[1] && !trn_d_ff;
	wire transition = bit_in != sh_ff[0];

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pri_sync_ff <= 2'h0;
			sec_sync_ff <= 2'h0;
			trn_sync_ff <= 2'h0;
			trn_d_ff <= 1'b0;
			sel_d_ff <= 1'b0;
			sh_ff <= 10'h000;
		end else if (clk_en_in) begin
			pri_sync_ff <= {pri_sync_ff[0], primary_serial_input_in};
			sec_sync_ff <= {sec_sync_ff[0], secondary_serial_input_in};
			trn_sync_ff <= {trn_sync_ff[0], training_clock_in};
			trn_d_ff <= trn_sync_ff[1];
			sel_d_ff <= line_input_select_in;
			sh_ff <= {sh_ff[8:0], bit_in};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// range monitor against the training clock
	logic [5:0] bc_ff;
	logic trk_ff;
	wire [5:0] trn_exp = training_rate_select_in ? rxf_pkg::TRN_RATIO_HALF : rxf_pkg::TRN_RATIO_CHAR;
	wire [5:0] trn_diff = (bc_ff > trn_exp) ? bc_ff - trn_exp : trn_exp - bc_ff;
	wire trn_off = trn_diff > 6'(TRN_TOL);
	wire trn_lost = &bc_ff;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bc_ff <= 6'h00;
			trk_ff <= 1'b1;
		end else if (clk_en_in) begin
			bc_ff <= trn_edge ? 6'h01 : (trn_lost ? bc_ff : bc_ff + 6'h01);
			if (trn_edge)
				trk_ff <= trn_off;
			else if (trn_lost)
				trk_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pattern detect
	wire comma_hit = sh_ff[9:2] == rxf_pkg::COMMA_POS || sh_ff[9:2] == rxf_pkg::COMMA_NEG;
	wire k285_hit = sh_ff == rxf_pkg::K285_NEG || sh_ff == rxf_pkg::K285_POS;
	wire pat_hit = (framing_pattern_select_in == rxf_pkg::SEL_HIGH) ? k285_hit :
		(framing_pattern_select_in == rxf_pkg::SEL_LOW) ? 1'b0 : comma_hit;
	wire det = global_framer_enable_in && pat_hit && !trk_ff;
	wire ll_mode = framer_type_select_in == rxf_pkg::SEL_LOW;
	wire alt_mode = framer_type_select_in == rxf_pkg::SEL_HIGH;

	////////////////////////////////////////////////////////////////////////////
	// boundary counters, low-latency stretch, multi-byte qualification
	rxf_pkg::rxf_sync_t state_ff, nxt_state;
	logic [3:0] dcnt_ff, ccnt_ff, slip_ff, ph_ff;
	logic [1:0] str_ff;
	logic [5:0] age_ff;
	logic [2:0] run_ff;
	wire hold = ll_mode && slip_ff != 4'h0 && dcnt_ff == 4'h0 && str_ff < rxf_pkg::MAX_STRETCH;
	wire dlast = dcnt_ff == rxf_pkg::CNT_LAST;
	wire clast = ccnt_ff == rxf_pkg::CNT_LAST;
	wire same_ph = dcnt_ff == ph_ff;
	wire mid_ok = run_ff != 3'h0 && same_ph && age_ff <= rxf_pkg::MB_SPAN_BITS - rxf_pkg::MB_CHAR_BITS;
	wire alt_step = run_ff != 3'h0 && same_ph && age_ff == rxf_pkg::MB_CHAR_BITS;
	wire alt_ok = alt_step && run_ff == rxf_pkg::MB_ALT_RUN - 3'h1;
	wire ll_det = det && ll_mode && slip_ff == 4'h0;
	wire mb_acc = det && !ll_mode && (alt_mode ? alt_ok : mid_ok);
	wire [3:0] ll_slip = dlast ? 4'h0 : dcnt_ff + 4'h1;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			rxf_pkg::RXF_HUNT: begin
				if (det)
					nxt_state = rxf_pkg::RXF_CHECK;
			end
			rxf_pkg::RXF_CHECK: begin
				if (mb_acc || (ll_mode && slip_ff == 4'h0 && !det))
					nxt_state = rxf_pkg::RXF_LOCK;
			end
			rxf_pkg::RXF_LOCK: begin
				if (ll_det && ll_slip != 4'h0)
					nxt_state = rxf_pkg::RXF_CHECK;
			end
			default: nxt_state = rxf_pkg::RXF_HUNT;
		endcase
		if (line_swap)
			nxt_state = rxf_pkg::RXF_HUNT;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= rxf_pkg::RXF_HUNT;
			dcnt_ff <= 4'h0;
			ccnt_ff <= 4'h0;
			slip_ff <= 4'h0;
			str_ff <= 2'h0;
		end else if (clk_en_in) begin
			state_ff <= nxt_state;
			if (hold) begin
				str_ff <= str_ff + 2'h1;
				slip_ff <= slip_ff - 4'h1;
			end else begin
				dcnt_ff <= mb_acc ? 4'h0 : (dlast ? 4'h0 : dcnt_ff + 4'h1);
				ccnt_ff <= clast ? 4'h0 : ccnt_ff + 4'h1;
				if (clast)
					str_ff <= 2'h0;
				if (ll_det)
					slip_ff <= ll_slip;
				else if (line_swap || !ll_mode)
					slip_ff <= 4'h0;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ph_ff <= 4'h0;
			age_ff <= 6'h00;
			run_ff <= 3'h0;
		end else if (clk_en_in) begin
			if (line_swap || mb_acc) begin
				run_ff <= 3'h0;
			end else if (det && !ll_mode) begin
				ph_ff <= dcnt_ff;
				age_ff <= 6'h01;
				run_ff <= alt_step ? run_ff + 3'h1 : 3'h1;
			end else if (!(&age_ff)) begin
				age_ff <= age_ff + 6'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transition density fault
	logic [6:0] quiet_ff;
	logic [1:0] good_ff;
	logic seen_ff, lfi_ff;
	wire char_has_tr = seen_ff || transition;
	wire [1:0] good_nx = (dlast && !hold) ? (char_has_tr ? good_ff + 2'h1 : 2'h0) : good_ff;
	wire lfi_set = trk_ff || quiet_ff > rxf_pkg::FAULT_QUIET_BITS;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			quiet_ff <= 7'h00;
			good_ff <= 2'h0;
			seen_ff <= 1'b0;
			lfi_ff <= 1'b1;
		end else if (clk_en_in) begin
			quiet_ff <= transition ? 7'h00 : (&quiet_ff ? quiet_ff : quiet_ff + 7'h01);
			seen_ff <= (dlast && !hold) ? 1'b0 : char_has_tr;
			if (lfi_set) begin
				lfi_ff <= 1'b1;
				good_ff <= 2'h0;
			end else if (lfi_ff) begin
				good_ff <= good_nx;
				if (good_nx == rxf_pkg::FAULT_GOOD_CHARS)
					lfi_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// 10b/8b decode and status
	logic rd_ff;
	wire k28_6 = sh_ff[9:4] == 6'b001111 || sh_ff[9:4] == 6'b110000;
	wire [5:0] d6 = dec6(sh_ff[9:4]);
	wire [3:0] d4 = dec4(sh_ff[4] ? ~sh_ff[3:0] : sh_ff[3:0]);
	wire [3:0] d4k = dec4(sh_ff[9:4] == 6'b110000 ? ~sh_ff[3:0] : sh_ff[3:0]);
	wire [3:0] d4u = k28_6 ? d4k : d4;
	wire k7_6 = d6[4:0] == 5'h17 || d6[4:0] == 5'h1B || d6[4:0] == 5'h1D || d6[4:0] == 5'h1E;
	wire k7 = !k28_6 && k7_6 && (sh_ff[3:0] == 4'b1000 || sh_ff[3:0] == 4'b0111);
	wire is_k = k28_6 || k7;
	wire dec_ok = d6[5] && d4u[3];
	wire [3:0] ones = 4'(sh_ff[0]) + 4'(sh_ff[1]) + 4'(sh_ff[2]) + 4'(sh_ff[3]) + 4'(sh_ff[4])
		+ 4'(sh_ff[5]) + 4'(sh_ff[6]) + 4'(sh_ff[7]) + 4'(sh_ff[8]) + 4'(sh_ff[9]);
	wire disp_err = (ones == 4'h6 && rd_ff) || (ones == 4'h4 && !rd_ff) || ones > 4'h6 || ones < 4'h4;
	wire [7:0] k_alt = k28_6 ? {5'h00, d4u[2:0]} :
		rxf_pkg::ALT_K7_BASE + {6'h00, d6[3] ? (d6[2] ? 2'h3 : 2'h2) : (d6[1] ? 2'h1 : 2'h0)};
	wire bypass = decoder_mode_select_in == rxf_pkg::SEL_LOW;
	wire alt_col = decoder_mode_select_in == rxf_pkg::SEL_HIGH;
	wire [7:0] dec_byte = (is_k && alt_col) ? k_alt : {d4u[2:0], d6[4:0]};
	wire [9:0] out_word = bypass ? sh_ff : {2'h0, dec_byte};
	wire [2:0] st_dec = !dec_ok ? rxf_pkg::ST_INVALID : disp_err ? rxf_pkg::ST_DISP :
		k285_hit ? rxf_pkg::ST_FRAME : is_k ? rxf_pkg::ST_SPECIAL : rxf_pkg::ST_DATA;
	wire [2:0] st_out = lfi_ff ? rxf_pkg::ST_NOSYNC : (bypass ? rxf_pkg::ST_DATA : st_dec);
	wire par_out = ~^out_word;

	////////////////////////////////////////////////////////////////////////////
	// character capture into the two-entry buffer
	rxf_stream_if #(.W(14)) sif ();
	logic pend_vld_ff, ovf_ff;
	logic [13:0] pend_ff;
	wire cap = dlast && !hold;
	wire push = pend_vld_ff && sif.wready;

	assign sif.wdata = pend_ff;
	assign sif.wvalid = pend_vld_ff;
	assign sif.rready = rx_ready_in;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend_vld_ff <= 1'b0;
			pend_ff <= 14'h0000;
			ovf_ff <= 1'b0;
			rd_ff <= 1'b0;
		end else if (clk_en_in) begin
			if (cap) begin
				pend_ff <= {par_out, st_out, out_word};
				pend_vld_ff <= 1'b1;
				if (ones != 4'h5)
					rd_ff <= ones > 4'h5;
				if (pend_vld_ff && !push)
					ovf_ff <= 1'b1;
			end else if (push) begin
				pend_vld_ff <= 1'b0;
			end
		end
	end

	rxf_skid_buf #(.WIDTH(14), .DEPTH(2)) u_buf (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.sif(sif)
	);

	////////////////////////////////////////////////////////////////////////////
	// recovered character clock and status flops
	logic rclk_ff, cfg_ff;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rclk_ff <= 1'b0;
			cfg_ff <= 1'b0;
		end else if (clk_en_in) begin
			if (output_clock_rate_select_in)
				rclk_ff <= (clast && !hold) ? ~rclk_ff : rclk_ff;
			else
				rclk_ff <= hold ? rclk_ff : (ccnt_ff + 4'h1 < rxf_pkg::CNT_HALF || clast);
			cfg_ff <= bypass && receive_clock_source_select_in != rxf_pkg::SEL_MID;
		end
	end

	assign recovered_char_clock_out = rclk_ff;
	assign link_fault_indicator_out = lfi_ff;
	assign tracking_training_out = trk_ff;
	assign framing_locked_out = state_ff[1];
	assign config_error_out = cfg_ff;
	assign overflow_out = ovf_ff;
	assign rx_data_out = sif.rdata[9:0];
	assign receive_status_code_out = sif.rdata[12:10];
	assign rx_parity_out = sif.rdata[13];
	assign rx_valid_out = sif.rvalid;
endmodule : rxf_rx_framer

// >>> verification/rxf_tx_model.sv
// far-end transmitter model: serial 8b10b characters and training clock
// assumes one serial bit per core clock, character bit 9 sent first
module rxf_tx_model (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// character feed
	input wire logic [9:0] char_in,
	input wire logic quiet_in,
	// line side
	output logic serial_out,
	output logic training_clock_out,
	output logic load_out
);
	logic [9:0] sh_ff;
	logic [3:0] bit_ff;
	logic [3:0] trn_ff;
	assign load_out = (bit_ff == 4'h9);
	// quiet holds the line flat to starve transitions
	assign serial_out = quiet_in ? 1'b0 : sh_ff[9];
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sh_ff <= 10'h2AA;
			bit_ff <= 4'h0;
			trn_ff <= 4'h0;
			training_clock_out <= 1'b0;
		end else begin
			sh_ff <= load_out ? char_in : {sh_ff[8:0], 1'b0};
			bit_ff <= load_out ? 4'h0 : bit_ff + 4'h1;
			// training clock at one tenth of the bit rate
			trn_ff <= (trn_ff == 4'h9) ? 4'h0 : trn_ff + 4'h1;
			training_clock_out <= (trn_ff < 4'h5);
		end
	end
endmodule : rxf_tx_model

// >>> verification/rxf_rx_framer_asserts.sv
// port checks for the receive framer channel
// assumes bind onto rxf_rx_framer, one core clock domain
module rxf_rx_framer_asserts (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// inputs
	input wire logic line_input_select_in,
	input wire logic primary_serial_input_in,
	input wire logic secondary_serial_input_in,
	input wire logic global_framer_enable_in,
	input wire logic output_clock_rate_select_in,
	input wire logic [1:0] decoder_mode_select_in,
	input wire logic [1:0] receive_clock_source_select_in,
	input wire logic rx_ready_in,
	// outputs
	input wire logic recovered_char_clock_out,
	input wire logic link_fault_indicator_out,
	input wire logic tracking_training_out,
	input wire logic framing_locked_out,
	input wire logic config_error_out,
	input wire logic overflow_out,
	input wire logic [9:0] rx_data_out,
	input wire logic [2:0] receive_status_code_out,
	input wire logic rx_parity_out,
	input wire logic rx_valid_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic sel_bit;
	logic prev_bit_ff;
	logic prev_clk_ff;
	logic [6:0] quiet_ff;
	logic [3:0] run_ff;
	assign sel_bit = line_input_select_in ? secondary_serial_input_in : primary_serial_input_in;
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev_bit_ff <= 1'b0;
			prev_clk_ff <= 1'b0;
			quiet_ff <= 7'h00;
			run_ff <= 4'h0;
		end else begin
			prev_bit_ff <= sel_bit;
			prev_clk_ff <= recovered_char_clock_out;
			quiet_ff <= (sel_bit != prev_bit_ff) ? 7'h00 : quiet_ff + {6'h00, quiet_ff != 7'h7F};
			run_ff <= (output_clock_rate_select_in || recovered_char_clock_out != prev_clk_ff) ? 4'h0 :
				run_ff + {3'h0, run_ff != 4'hF};
		end
	end
	////////////////////////////////
	a_parity_odd: assert property (rx_valid_out |-> ^{rx_data_out, rx_parity_out})
		else $error("parity not odd");
	a_cfg_error: assert property (config_error_out == $past(decoder_mode_select_in == rxf_pkg::SEL_LOW &&
		receive_clock_source_select_in != rxf_pkg::SEL_MID)) else $error("config error flag wrong");
	a_valid_holds: assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out &&
		$stable({rx_data_out, receive_status_code_out, rx_parity_out})) else $error("output word moved");
	a_fault_quiet: assert property (quiet_ff == 7'h46 |-> link_fault_indicator_out)
		else $error("no fault after quiet line");
	a_track_unlocked: assert property (tracking_training_out |-> !framing_locked_out)
		else $error("locked while tracking");
	a_disabled_hold: assert property (!global_framer_enable_in && !framing_locked_out |=> !framing_locked_out)
		else $error("framing while disabled");
	a_swap_reframe: assert property ($changed(line_input_select_in) |-> ##[1:2] !framing_locked_out)
		else $error("no reframe after swap");
	a_overflow_sticky: assert property (overflow_out |=> overflow_out)
		else $error("overflow cleared");
	a_stretch_max: assert property (run_ff <= 4'h6)
		else $error("char clock stretched too far");
	c_lock: cover property ($rose(framing_locked_out));
	c_ovf: cover property ($rose(overflow_out));
	c_bypass: cover property (rx_valid_out && decoder_mode_select_in == rxf_pkg::SEL_LOW);
endmodule : rxf_rx_framer_asserts
bind rxf_rx_framer rxf_rx_framer_asserts rxf_rx_framer_asserts_i (.*);

// >>> verification/rxf_rx_framer_tb.sv
// self-checking bench for the receive framer channel
// assumes rxf_tx_model as far-end transmitter and the bound checker
module rxf_rx_framer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic clk_en_in = 1'b1;
	logic primary_serial_input_in;
	logic secondary_serial_input_in;
	logic training_clock_in;
	logic line_input_select_in = 1'b0;
	logic training_rate_select_in = 1'b0;
	logic [1:0] framing_pattern_select_in = 2'h2;
	logic [1:0] framer_type_select_in = 2'h2;
	logic global_framer_enable_in = 1'b1;
	logic output_clock_rate_select_in = 1'b0;
	logic [1:0] decoder_mode_select_in = 2'h1;
	logic [1:0] receive_clock_source_select_in = 2'h1;
	logic rx_ready_in = 1'b1;
	logic recovered_char_clock_out;
	logic link_fault_indicator_out;
	logic tracking_training_out;
	logic framing_locked_out;
	logic config_error_out;
	logic overflow_out;
	logic [9:0] rx_data_out;
	logic [2:0] receive_status_code_out;
	logic rx_parity_out;
	logic rx_valid_out;
	logic [9:0] char_in = 10'h2AA;
	logic quiet_in = 1'b0;
	logic load_out;
	int fails = 0;
	int check_count = 0;
	wire [13:0] out_word = {rx_parity_out, receive_status_code_out, rx_data_out};
	always #20 core_clk_in = ~core_clk_in;
	assign secondary_serial_input_in = primary_serial_input_in;
	rxf_rx_framer rxf_rx_framer_i (.*);
	rxf_tx_model rxf_tx_model_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .char_in(char_in),
		.quiet_in(quiet_in), .serial_out(primary_serial_input_in), .training_clock_out(training_clock_in),
		.load_out(load_out));
	////////////////////////////////
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	task automatic cmp_word(input logic [13:0] got, input logic [13:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic cmp_flag(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_flag
	task automatic cycles(input int n);
		repeat (n) @(negedge core_clk_in);
	endtask : cycles
	task automatic put(input logic [9:0] c);
		int i;
		for (i = 0; i < 20 && load_out !== 1'b1; i++) @(negedge core_clk_in);
		cmp_flag(load_out, 1'b1);
		if (i == 20) final_report;
		char_in = c;
		@(negedge core_clk_in);
		char_in = 10'h2AA;
	endtask : put
	task automatic seek(input logic [13:0] exp);
		int i;
		for (i = 0; i < 800 && !(rx_valid_out === 1'b1 && out_word === exp); i++) @(negedge core_clk_in);
		cmp_word(out_word, exp);
		if (i == 800) final_report;
	endtask : seek
	task automatic wait_flag(input bit fault, input logic val);
		int i;
		for (i = 0; i < 400 && (fault ? link_fault_indicator_out : tracking_training_out) !== val; i++)
			@(negedge core_clk_in);
		cmp_flag(fault ? link_fault_indicator_out : tracking_training_out, val);
		if (i == 400) final_report;
	endtask : wait_flag
	task automatic commas;
		int i;
		for (i = 0; i < 8; i++) put(i[0] ? 10'h305 : 10'h0FA);
		put(10'h0F4);
	endtask : commas
	////////////////////////////////
	task automatic t_frame(input logic [1:0] p, input logic [1:0] m);
		framing_pattern_select_in = p;
		framer_type_select_in = m;
		line_input_select_in = ~line_input_select_in;
		cycles(2);
		cmp_flag(framing_locked_out, 1'b0);
		commas;
		// last framing char reaches the shifter two cycles after the next char's load
		cycles(6);
		cmp_flag(framing_locked_out, 1'b1);
		seek(14'h041C);
	endtask : t_frame
	task automatic t_nolock(input logic e, input logic [1:0] p);
		global_framer_enable_in = e;
		framing_pattern_select_in = p;
		line_input_select_in = ~line_input_select_in;
		commas;
		cmp_flag(framing_locked_out, 1'b0);
		global_framer_enable_in = 1'b1;
		framing_pattern_select_in = 2'h2;
	endtask : t_nolock
	task automatic t_modes;
		decoder_mode_select_in = 2'h2;
		put(10'h0F4);
		seek(14'h2400);
		decoder_mode_select_in = 2'h0;
		seek(14'h02AA);
		receive_clock_source_select_in = 2'h0;
		cycles(2);
		cmp_flag(config_error_out, 1'b1);
		receive_clock_source_select_in = 2'h1;
		decoder_mode_select_in = 2'h1;
		cycles(2);
		cmp_flag(config_error_out, 1'b0);
	endtask : t_modes
	task automatic t_stall;
		rx_ready_in = 1'b0;
		cycles(60);
		cmp_flag(overflow_out, 1'b1);
		cmp_flag(rx_valid_out, 1'b1);
		rx_ready_in = 1'b1;
		seek(14'h00B5);
	endtask : t_stall
	task automatic t_fault;
		quiet_in = 1'b1;
		cycles(80);
		cmp_flag(link_fault_indicator_out, 1'b1);
		quiet_in = 1'b0;
		wait_flag(1'b1, 1'b0);
	endtask : t_fault
	////////////////////////////////
	initial begin
		repeat (3) @(negedge core_clk_in);
		cmp_flag(link_fault_indicator_out, 1'b1);
		cmp_flag(tracking_training_out, 1'b1);
		cmp_flag(rx_valid_out, 1'b0);
		rst_n_in = 1'b1;
		wait_flag(1'b0, 1'b0);
		wait_flag(1'b1, 1'b0);
		// low-latency, multi-byte and alternate multi-byte framers in turn
		t_frame(2'h2, 2'h0);
		t_frame(2'h1, 2'h1);
		t_frame(2'h2, 2'h2);
		t_modes;
		t_stall;
		t_fault;
		t_nolock(1'b0, 2'h2);
		t_nolock(1'b1, 2'h0);
		final_report;
	end
endmodule : rxf_rx_framer_tb
